// >>> core/asrc_params.svh
// Purpose: Timing and width constants for the asynchronous static memory controller.
// Assumes: 50 MHz clock, 20 ns period; 45 ns speed grade of the memory.
// Notes: Least times round up to whole cycles; a time of zero gives zero cycles.
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
// ==========================================================
// Clock
`define ASRC_CLK_NS 20
// ==========================================================
// Memory timing in ns
`define ASRC_T_RC_NS 45
`define ASRC_T_AA_NS 45
`define ASRC_T_HZ_NS 15
`define ASRC_T_WP_NS 35
`define ASRC_T_AW_NS 40
`define ASRC_T_WRITE_DATA_SETUP_NS 20
`define ASRC_T_OW_NS 5
// Extra cycles so read data has crossed the three-stage synchroniser.
`define ASRC_SYNC_CYC 3
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
// ==========================================================
// Geometry
`define ASRC_ADDR_W 21
`define ASRC_DATA_W 8
`define ASRC_CNT_W 4
`endif

// >>> core/asrc_pkg.sv
// Purpose: Types for the asynchronous static memory controller.
// Assumes: Constants come from asrc_params.svh.
// Notes: Address and control pins travel as one packed struct; the data lines are separate ports.
`include "asrc_params.svh"
package asrc_pkg;
    // ==========================================================
    // Pin group toward the memory
    typedef struct packed {
        logic [`ASRC_ADDR_W-1:0] word_address_lines;
        logic select_low_active_n;
        logic select_high_active;
        logic out_enable_n;
        logic write_enable_n;
    } asrc_pins_t;
    // ==========================================================
    // Controller states
    typedef enum logic [6:0] {
        ASRC_IDLE = 7'h01,
        ASRC_RD = 7'h02,
        ASRC_WR = 7'h04,
        ASRC_WREC = 7'h08,
        ASRC_TURN = 7'h10,
        ASRC_RET = 7'h20,
        ASRC_RECOV = 7'h40
    } asrc_state_t;
endpackage

// >>> core/asrc_timer.sv
// Purpose: Down counter that marks when a programmed number of cycles has passed.
// Assumes: Load and run are from the same clock domain.
// Notes: done is high while the count is zero.
`include "asrc_params.svh"
module asrc_timer #(
    parameter int CW = `ASRC_CNT_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [CW-1:0] value,
    output logic done
);
    logic [CW-1:0] cnt_r;
    if (CW < 2) begin : g_bad_cw
        $error("asrc_timer: counter too narrow");
    end
    // ==========================================================
    // Counter
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= value;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
    assign done = (cnt_r == '0);
endmodule

// >>> core/asrc_ctrl.sv
// Purpose: Host controller that reads and writes an asynchronous 2M x 8 static memory.
// Assumes: 50 MHz clock; memory pins are driven straight from flip-flops.
// Notes: One access at a time; retention entry is requested by a level.
`include "asrc_params.svh"
module asrc_ctrl
    import asrc_pkg::*;
#(
    parameter int AW = `ASRC_ADDR_W,
    parameter int DW = `ASRC_DATA_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [AW-1:0] req_addr,
    input wire logic [DW-1:0] req_wdata,
    output logic req_ready,
    output logic [DW-1:0] rsp_rdata,
    output logic rsp_valid,
    input wire logic retain_req,
    output logic retain_ack,
    output asrc_pins_t mem_pins,
    input wire logic [DW-1:0] shared_data_lines_in,
    output logic [DW-1:0] shared_data_lines_out,
    output logic shared_data_lines_oe
);
    localparam logic [`ASRC_CNT_W-1:0] RD_CYC = `ASRC_CNT_W'(`ASRC_CYC_UP(`ASRC_T_AA_NS));
    localparam int WP_MIN_NS = `ASRC_T_HZ_NS + `ASRC_T_WRITE_DATA_SETUP_NS + 1;
    localparam logic [`ASRC_CNT_W-1:0] WP_CYC = `ASRC_CNT_W'(`ASRC_CYC_UP(
        `ASRC_T_WP_NS > WP_MIN_NS ? `ASRC_T_WP_NS : WP_MIN_NS));
    localparam logic [`ASRC_CNT_W-1:0] SYNC_CYC = `ASRC_CNT_W'(`ASRC_SYNC_CYC);
    localparam logic [`ASRC_CNT_W-1:0] HZ_CYC = `ASRC_CNT_W'(`ASRC_CYC_UP(`ASRC_T_HZ_NS));
    localparam logic [`ASRC_CNT_W-1:0] RC_CYC = `ASRC_CNT_W'(`ASRC_CYC_UP(`ASRC_T_RC_NS));
    if (AW != `ASRC_ADDR_W) begin : g_bad_aw
        $error("asrc_ctrl: address width must be 21");
    end
    if (DW != `ASRC_DATA_W) begin : g_bad_dw
        $error("asrc_ctrl: data width must be 8");
    end

    asrc_state_t state_r;
    asrc_state_t state_nxt;
    logic tmr_load;
    logic [`ASRC_CNT_W-1:0] tmr_value;
    logic tmr_done;
    logic [DW-1:0] rdata_sync1_r;
    logic [DW-1:0] rdata_sync2_r;
    logic [DW-1:0] rdata_sync3_r;
    logic ret_s1_r;
    logic ret_s2_r;
    logic ret_s3_r;
    logic ret_lvl_r;

    asrc_timer #(.CW(`ASRC_CNT_W)) asrc_timer_inst (
        .clock(clock),
        .rst(rst),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    // ==========================================================
    // Input synchronisers
    // The read bus is asynchronous to this clock, so data is taken only after
    // the second and third stages agree; the access wait covers this margin.
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_sync1_r <= '0;
            rdata_sync2_r <= '0;
            rdata_sync3_r <= '0;
            ret_s1_r <= 1'b0;
            ret_s2_r <= 1'b0;
            ret_s3_r <= 1'b0;
            ret_lvl_r <= 1'b0;
        end else begin
            rdata_sync1_r <= shared_data_lines_in;
            rdata_sync2_r <= rdata_sync1_r;
            rdata_sync3_r <= rdata_sync2_r;
            ret_s1_r <= retain_req;
            ret_s2_r <= ret_s1_r;
            ret_s3_r <= ret_s2_r;
            if (ret_s2_r == ret_s3_r) begin
                ret_lvl_r <= ret_s3_r;
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_value = RD_CYC;
        unique case (state_r)
            ASRC_IDLE: begin
                // A request offered while ready was shown is served before retention,
                // so the user never sees a taken request dropped.
                if (req_valid && req_ready && req_write) begin
                    state_nxt = ASRC_WR;
                    tmr_load = 1'b1;
                    tmr_value = WP_CYC;
                end else if (req_valid && req_ready) begin
                    state_nxt = ASRC_RD;
                    tmr_load = 1'b1;
                    tmr_value = RD_CYC + SYNC_CYC;
                end else if (ret_lvl_r) begin
                    state_nxt = ASRC_RET;
                end
            end
            ASRC_RD: begin
                if (tmr_done && rdata_sync2_r == rdata_sync3_r) begin
                    state_nxt = ASRC_TURN;
                    tmr_load = 1'b1;
                    tmr_value = HZ_CYC;
                end
            end
            ASRC_WR: begin
                if (tmr_done) begin
                    state_nxt = ASRC_WREC;
                end
            end
            ASRC_WREC: begin
                state_nxt = ASRC_IDLE;
            end
            ASRC_TURN: begin
                if (tmr_done) begin
                    state_nxt = ASRC_IDLE;
                end
            end
            ASRC_RET: begin
                if (!ret_lvl_r) begin
                    state_nxt = ASRC_RECOV;
                    tmr_load = 1'b1;
                    tmr_value = RC_CYC;
                end
            end
            ASRC_RECOV: begin
                if (tmr_done) begin
                    state_nxt = ASRC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ASRC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Memory pins
    // Address and selects change together and stay until the access ends, so
    // the address is never later than the selects.
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_pins.word_address_lines <= '0;
            mem_pins.select_low_active_n <= 1'b1;
            mem_pins.select_high_active <= 1'b0;
            mem_pins.out_enable_n <= 1'b1;
            mem_pins.write_enable_n <= 1'b1;
        end else if (state_r == ASRC_IDLE && state_nxt == ASRC_RD) begin
            mem_pins.word_address_lines <= req_addr;
            mem_pins.select_low_active_n <= 1'b0;
            mem_pins.select_high_active <= 1'b1;
            mem_pins.out_enable_n <= 1'b0;
            mem_pins.write_enable_n <= 1'b1;
        end else if (state_r == ASRC_IDLE && state_nxt == ASRC_WR) begin
            // Output enable stays high so the memory never drives during a write.
            mem_pins.word_address_lines <= req_addr;
            mem_pins.select_low_active_n <= 1'b0;
            mem_pins.select_high_active <= 1'b1;
            mem_pins.out_enable_n <= 1'b1;
            mem_pins.write_enable_n <= 1'b0;
        end else if (state_nxt == ASRC_WREC) begin
            mem_pins.write_enable_n <= 1'b1;
        end else if (state_nxt == ASRC_IDLE || state_nxt == ASRC_TURN ||
                     state_nxt == ASRC_RET || state_nxt == ASRC_RECOV) begin
            mem_pins.select_low_active_n <= 1'b1;
            mem_pins.select_high_active <= 1'b0;
            mem_pins.out_enable_n <= 1'b1;
            mem_pins.write_enable_n <= 1'b1;
        end
    end

    // ==========================================================
    // Data bus drive
    always_ff @(posedge clock) begin
        if (rst) begin
            shared_data_lines_out <= '0;
            shared_data_lines_oe <= 1'b0;
        end else if (state_r == ASRC_IDLE && state_nxt == ASRC_WR) begin
            shared_data_lines_out <= req_wdata;
            shared_data_lines_oe <= 1'b1;
        end else if (state_r == ASRC_WREC) begin
            shared_data_lines_oe <= 1'b0;
        end
    end

    // ==========================================================
    // User side
    always_ff @(posedge clock) begin
        if (rst) begin
            rsp_rdata <= '0;
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            retain_ack <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_r == ASRC_RD && state_nxt == ASRC_TURN) begin
                rsp_rdata <= rdata_sync3_r;
                rsp_valid <= 1'b1;
            end
            req_ready <= (state_nxt == ASRC_IDLE) && !ret_lvl_r;
            retain_ack <= (state_nxt == ASRC_RET);
        end
    end
endmodule

// >>> sim/asrc_ctrl_assertions.sv
// Purpose: Pin timing checks for the static memory controller.
// Assumes: 50 MHz clock, so one cycle is 20 ns.
// Notes: Sees only the controller's ports.
// ==========================================================
// Checker
module asrc_ctrl_checker
    import asrc_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic retain_ack,
    input wire asrc_pins_t mem_pins,
    input wire logic [DW-1:0] shared_data_lines_out,
    input wire logic shared_data_lines_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire sel = !mem_pins.select_low_active_n && mem_pins.select_high_active;
    wire we_n = mem_pins.write_enable_n;
    wire oe_n = mem_pins.out_enable_n;
    property p_rd_we; sel && !oe_n |-> we_n; endproperty
    a_rd_we: assert property (p_rd_we) else $error("write enable low in read");
    property p_wr_sel; !we_n |-> sel && oe_n; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write without select");
    property p_wr_len; $fell(we_n) |-> (sel && !we_n)[*3] ##1 (sel && we_n); endproperty
    a_wr_len: assert property (p_wr_len) else $error("write pulse too short");
    property p_idle_quiet; req_ready |-> !sel && oe_n && we_n && !shared_data_lines_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pins active while ready");
    property p_addr_hold; sel && $past(sel) |-> $stable(mem_pins.word_address_lines); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_data_setup; !we_n |-> shared_data_lines_oe ##1 $stable(shared_data_lines_out);
    endproperty
    a_data_setup: assert property (p_data_setup) else $error("write data late");
    property p_data_hold; $rose(we_n) |-> shared_data_lines_oe; endproperty
    a_data_hold: assert property (p_data_hold) else $error("data dropped early");
    property p_no_fight; shared_data_lines_oe |-> oe_n && $past(oe_n); endproperty
    a_no_fight: assert property (p_no_fight) else $error("bus contention");
    property p_rd_len; $fell(oe_n) |-> (sel && !oe_n)[*3]; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read access cut short");
    property p_ret; retain_ack |-> !sel; endproperty
    a_ret: assert property (p_ret) else $error("selected in retention");
    property p_recov; $fell(retain_ack) |-> (!sel)[*3]; endproperty
    a_recov: assert property (p_recov) else $error("recovery too short");
    c_write: cover property ($fell(we_n));
    c_read: cover property ($fell(oe_n));
    c_ret: cover property ($rose(retain_ack));
endmodule
bind asrc_ctrl asrc_ctrl_checker #(.DW(DW)) asrc_ctrl_checker_inst (.clock(clock), .rst(rst),
    .req_ready(req_ready), .retain_ack(retain_ack), .mem_pins(mem_pins),
    .shared_data_lines_out(shared_data_lines_out), .shared_data_lines_oe(shared_data_lines_oe));

// >>> sim/asrc_sram_model.sv
// Purpose: Behavioural 2M x 8 static memory with its pin delays.
// Assumes: Bus level is resolved by the bench.
// Notes: ACC_NS may be raised to play a slow part.
module asrc_sram_model
    import asrc_pkg::*;
#(
    parameter int ACC_NS = 45
) (
    input wire asrc_pins_t pins,
    input wire logic [7:0] bus,
    output logic mem_oe,
    output logic [7:0] mem_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [logic [20:0]];
    wire sel = !pins.select_low_active_n && pins.select_high_active;
    wire wr = sel && !pins.write_enable_n;
    wire rd = sel && !pins.out_enable_n && pins.write_enable_n;
    initial mem_oe = 1'b0;
    initial mem_dout = 8'h00;
    function automatic logic [7:0] fetch(input logic [20:0] a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction
    // Capture at the end of the write, where the data hold time is zero.
    always @(negedge wr) begin
        if (!$isunknown(pins.word_address_lines)) mem[pins.word_address_lines] = bus;
    end
    always @(rd or pins.word_address_lines) begin
        if (rd) begin
            mem_oe <= #5 1'b1;
            mem_dout <= #10 ~fetch(pins.word_address_lines);
            mem_dout <= #(ACC_NS) fetch(pins.word_address_lines);
        end else begin
            mem_oe <= #15 1'b0;
        end
    end
endmodule

// >>> sim/asrc_ctrl_bench.sv
// Purpose: Self-checking bench for the static memory controller.
// Assumes: 50 MHz clock, reset held for three cycles.
// Notes: A released bus shows a pattern that flips every cycle.
module asrc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import asrc_pkg::*;
    logic clock, rst, req_valid, req_write, retain_req;
    logic [20:0] req_addr;
    logic [7:0] req_wdata, rsp_rdata, ctl_out, mem_dout;
    logic [7:0] float_r = 8'h5A;
    logic req_ready, rsp_valid, retain_ack, ctl_oe, mem_oe;
    asrc_pins_t pins;
    wire [7:0] bus = ctl_oe ? ctl_out : (mem_oe ? mem_dout : float_r);
    int err_total, compares;
    // ==========================================================
    // Instances
    asrc_ctrl asrc_ctrl_inst (.clock(clock), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
        .retain_req(retain_req), .retain_ack(retain_ack), .mem_pins(pins),
        .shared_data_lines_in(bus), .shared_data_lines_out(ctl_out),
        .shared_data_lines_oe(ctl_oe));
    asrc_sram_model asrc_sram_model_inst (.pins(pins), .bus(bus), .mem_oe(mem_oe),
        .mem_dout(mem_dout));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) float_r <= ~float_r;
    // ==========================================================
    // Shared tasks
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task stop_test;
        if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task access(input logic w, input logic [20:0] a, input logic [7:0] d);
        int n;
        n = 0;
        // One edge with the strobe low between two requests.
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 80);
        req_valid <= 1'b0;
        check("req_ready", 1, req_ready);
    endtask
    task read_expect(input logic [20:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        access(1'b0, a, 8'h00);
        do begin
            @(posedge clock);
            n++;
        end while (rsp_valid !== 1'b1 && n < 40);
        check("rsp_valid", 1, rsp_valid);
        check("rsp_rdata", exp, rsp_rdata);
    endtask
    // ==========================================================
    // Scenarios
    task t_reset;
        check("select_low_active_n", 1, pins.select_low_active_n);
        check("write_enable_n", 1, pins.write_enable_n);
        check("shared_data_lines_oe", 0, ctl_oe);
    endtask
    task automatic t_corners;
        logic [20:0] a [3] = '{21'h000000, 21'h1FFFFF, 21'h0AAAAA};
        logic [7:0] d [3] = '{8'h5A, 8'hA5, 8'hFF};
        for (int i = 0; i < 3; i++) access(1'b1, a[i], d[i]);
        for (int i = 0; i < 3; i++) read_expect(a[i], d[i]);
    endtask
    task t_overwrite;
        access(1'b1, 21'h000123, 8'h11);
        access(1'b1, 21'h000123, 8'h3C);
        read_expect(21'h000123, 8'h3C);
    endtask
    task t_retention;
        int n;
        n = 0;
        retain_req <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (retain_ack !== 1'b1 && n < 20);
        check("retain_ack", 1, retain_ack);
        fork
            read_expect(21'h000123, 8'h3C);
            begin
                repeat (8) @(posedge clock);
                check("req_ready", 0, req_ready);
                check("select_high_active", 0, pins.select_high_active);
                retain_req <= 1'b0;
            end
        join
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 21'h000000;
        req_wdata = 8'h00;
        retain_req = 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        @(posedge clock);
        t_corners;
        t_overwrite;
        t_retention;
        stop_test;
    end
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        stop_test;
    end
endmodule
